// ---- src/slpm_consts.vh ----
// Constants for the sleep mode and clock gating controller
// How it works
// - Sleep starts only if sleep enable is set when sleep instruction executes.
// - After wake-up the core stays halted four extra cycles, then resumes.
// - Mode 000 Idle stops core and flash clocks only.
// - Idle wakes on external and internal peripheral interrupts.
// - Entering Idle or noise reduction with converter enabled starts a conversion.
// - Mode 001 noise reduction stops io, core and flash clocks.
// - Noise reduction wakes only on resets or converter, timer, display, serial start, memory-ready or pin sources.
// - Mode 010 Power-down stops oscillator and all generated clocks.
// - Power-down wakes only on resets, serial start, level zero or pin change.
// - Power-down wake-up waits a settle delay chosen by clock source select.
// - Mode 011 Power-save is Power-down but timer 2 and display keep running.
// - Power-save wakes on masked timer 2 events with global enable, or display.
// - Power-save keeps timer oscillator only for async users, main oscillator only for sync users or debug.
// - Mode 110 with crystal is Standby: oscillator runs, resume within six cycles.
// - A set power reduction bit stops, freezes and locks out that peripheral.
// - Clearing the bit restarts the clock with the state kept.
// - Peripheral clock stopping acts in Active and Idle.
// - Enabled converter stays on in sleep; re-enable makes next conversion extended.
// - Comparator is disabled in deep sleep unless it uses the internal reference.
// - Internal reference powered only when detector, comparator or converter need it.
// - Enabled watchdog and brown-out detector stay active in every sleep mode.
// - Digital input buffers off when io and converter clocks both stop.
// - Debug enabled keeps main oscillator running in Power-down and Power-save.
`ifndef SLPM_CONSTS_VH
`define SLPM_CONSTS_VH

// Register indices, byte address is four times the index
`define SLPM_IDX_SLEEP_CTRL    10'h033
`define SLPM_IDX_PWR_RED       10'h034
`define SLPM_IDX_STATUS        10'h035

// sleep_control_reg fields
`define SLPM_SE_BIT            0
`define SLPM_MODE_LSB          1
`define SLPM_MODE_MSB          3
`define SLPM_SLEEP_CTRL_RST    4'h0

// power_reduction_reg fields
`define SLPM_PR_CONV           0
`define SLPM_PR_USART          1
`define SLPM_PR_SPI            2
`define SLPM_PR_TIM1           3
`define SLPM_PR_DISP           4
`define SLPM_PR_RST            5'h00

// Mode codes
`define SLPM_M_IDLE            3'h0
`define SLPM_M_CNR             3'h1
`define SLPM_M_PDOWN           3'h2
`define SLPM_M_PSAVE           3'h3
`define SLPM_M_STBY            3'h6

// Timing counts in core clock cycles
`define SLPM_HALT_CYC          17'h0_0004
`define SLPM_STBY_CYC          17'h0_0006
`define SLPM_NO_DLY            16'h0000

`define SLPM_RDATA_RST         32'h0000_0000

`endif

// ---- src/slpm_dcnt.v ----
// Loadable down counter with a one-cycle done pulse
module slpm_dcnt #(
	parameter W = 17
) (
	input  wire         pclk,
	input  wire         presetn,
	input  wire         load,
	input  wire [W-1:0] load_val,
	output wire         busy,
	output wire         done
);
	reg [W-1:0] cnt_ff;
	reg         done_ff;
	reg [W-1:0] nxt_cnt;

	always @* begin
		nxt_cnt = cnt_ff;
		if (load) begin
			nxt_cnt = load_val;
		end else if (cnt_ff != {W{1'b0}}) begin
			nxt_cnt = cnt_ff - {{(W-1){1'b0}}, 1'b1};
		end
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_ff  <= {W{1'b0}};
			done_ff <= 1'b0;
		end else begin
			cnt_ff  <= nxt_cnt;
			done_ff <= !load && (cnt_ff == {{(W-1){1'b0}}, 1'b1});
		end
	end

	assign busy = (cnt_ff != {W{1'b0}});
	assign done = done_ff;
endmodule // slpm_dcnt

// ---- src/slpm_ctrl.v ----
// Sleep mode controller: mode decode, clock gating, wake-up and APB registers
`include "slpm_consts.vh"
module slpm_ctrl #(
	parameter [15:0] WAKE_XTAL_CYC = 16'h4000,
	parameter [15:0] WAKE_RC_CYC   = 16'h0040
) (
	input  wire        pclk,
	input  wire        presetn,
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [11:0] paddr,
	input  wire [31:0] pwdata,
	output wire [31:0] prdata,
	output wire        pready,
	output wire        pslverr,
	input  wire        sleep_instr,
	input  wire [3:0]  clock_source_select,
	input  wire        debug_enable_fuse,
	input  wire        brownout_enable,
	input  wire        watchdog_enable,
	input  wire        global_irq_en,
	input  wire        t2_ovf_irq_en,
	input  wire        t2_cmp_irq_en,
	input  wire        t2_enabled,
	input  wire        t2_async,
	input  wire        disp_enabled,
	input  wire        disp_async,
	input  wire        conv_enabled,
	input  wire        conv_begin,
	input  wire        comparator_disable_bit,
	input  wire        comparator_uses_ref,
	input  wire        reset_wake,
	input  wire        external_irq_zero,
	input  wire        ext_irq_edge,
	input  wire        pin_change,
	input  wire        serial_start,
	input  wire        conv_done_irq,
	input  wire        display_irq,
	input  wire        timer2_ovf,
	input  wire        timer2_cmp,
	input  wire        nvm_ready_irq,
	input  wire        other_io_irq,
	output wire        core_halt,
	output wire        core_resume,
	output wire        core_clock,
	output wire        flash_clock,
	output wire        io_clock,
	output wire        converter_clock,
	output wire        async_clock,
	output wire        t2_disp_sync_clk_en,
	output wire        main_osc_en,
	output wire        timer_osc_en,
	output wire [4:0]  periph_clk_en,
	output wire [4:0]  periph_reg_access_en,
	output wire        conv_start,
	output wire        conv_extended,
	output wire        comparator_off,
	output wire        vref_en,
	output wire        watchdog_run,
	output wire        brownout_run,
	output wire        dig_input_en,
	output wire        wake_input_en
);
	localparam [1:0] ST_ACTIVE = 2'h0;
	localparam [1:0] ST_SLEEP  = 2'h1;
	localparam [1:0] ST_WAKE   = 2'h2;

	reg  [1:0]  state_ff;
	reg  [1:0]  nxt_state;
	reg  [2:0]  mode_ff;
	reg  [2:0]  nxt_mode;
	reg  [3:0]  sctl_ff;
	reg  [4:0]  prr_ff;
	reg  [31:0] prdata_ff;
	reg         resume_ff;
	reg         conv_start_ff;
	reg         cen_d_ff;
	reg         ext_ff;
	reg         cpu_ff;
	reg         fls_ff;
	reg         io_ff;
	reg         cnv_ff;
	reg         asy_ff;
	reg         sync_ff;
	reg         mosc_ff;
	reg         tosc_ff;
	reg         cmp_off_ff;
	reg         vref_ff;
	reg         dib_ff;
	reg  [4:0]  pclk_en_ff;
	reg         nxt_cpu;
	reg         nxt_fls;
	reg         nxt_io;
	reg         nxt_cnv;
	reg         nxt_asy;
	reg         nxt_sync;
	reg         nxt_mosc;
	reg         nxt_tosc;
	reg         nxt_cmp_off;
	reg  [2:0]  eff_mode;
	reg         wake_hit;
	reg  [15:0] start_dly;
	reg  [31:0] rd_mux;
	reg         addr_hit;
	wire        cnt_load;
	wire [16:0] cnt_val;
	wire        cnt_busy;
	wire        cnt_done;
	wire        xtal_sel;
	wire        sleep_take;
	wire        apb_wr;
	wire [9:0]  widx;
	wire        t2_wake;
	wire        t2_sync_use;
	wire        disp_sync_use;
	wire        asy_use;
	wire [16:0] stby_start;

	// Crystal or resonator options occupy the upper half of the source codes
	assign xtal_sel = clock_source_select[3];
	assign widx     = paddr[11:2];
	assign apb_wr   = psel && penable && pwrite && addr_hit;

	// Mode decode with fallback for unsupported codes
	always @* begin
		case (sctl_ff[`SLPM_MODE_MSB:`SLPM_MODE_LSB])
			`SLPM_M_IDLE: begin
				eff_mode = `SLPM_M_IDLE;
			end
			`SLPM_M_CNR: begin
				eff_mode = `SLPM_M_CNR;
			end
			`SLPM_M_PDOWN: begin
				eff_mode = `SLPM_M_PDOWN;
			end
			`SLPM_M_PSAVE: begin
				eff_mode = `SLPM_M_PSAVE;
			end
			`SLPM_M_STBY: begin
				eff_mode = xtal_sel ? `SLPM_M_STBY : `SLPM_M_IDLE;
			end
			default: begin
				eff_mode = `SLPM_M_IDLE;
			end
		endcase
	end

	assign sleep_take = (state_ff == ST_ACTIVE) && sleep_instr && sctl_ff[`SLPM_SE_BIT];
	assign t2_wake    = ((timer2_ovf && t2_ovf_irq_en) || (timer2_cmp && t2_cmp_irq_en))
		&& global_irq_en;

	// Wake qualification per mode
	always @* begin
		case (mode_ff)
			`SLPM_M_IDLE: begin
				wake_hit = external_irq_zero || ext_irq_edge || pin_change || serial_start
					|| conv_done_irq || display_irq || timer2_ovf || timer2_cmp
					|| nvm_ready_irq || other_io_irq;
			end
			`SLPM_M_CNR: begin
				wake_hit = conv_done_irq || display_irq || serial_start || timer2_ovf
					|| timer2_cmp || nvm_ready_irq || external_irq_zero
					|| pin_change;
			end
			`SLPM_M_PSAVE: begin
				wake_hit = serial_start || external_irq_zero || pin_change || t2_wake
					|| display_irq;
			end
			default: begin
				wake_hit = serial_start || external_irq_zero || pin_change;
			end
		endcase
		wake_hit = wake_hit || reset_wake;
	end

	assign stby_start = `SLPM_STBY_CYC - `SLPM_HALT_CYC;

	// Start-up delay before the four halt cycles
	always @* begin
		case (mode_ff)
			`SLPM_M_PDOWN, `SLPM_M_PSAVE: begin
				start_dly = xtal_sel ? WAKE_XTAL_CYC : WAKE_RC_CYC;
			end
			`SLPM_M_STBY: begin
				start_dly = stby_start[15:0];
			end
			default: begin
				start_dly = `SLPM_NO_DLY;
			end
		endcase
	end

	assign cnt_load = (state_ff == ST_SLEEP) && wake_hit;
	assign cnt_val  = {1'b0, start_dly} + `SLPM_HALT_CYC;

	slpm_dcnt #(
		.W (17)
	) u_wake_cnt (
		.pclk     (pclk),
		.presetn  (presetn),
		.load     (cnt_load),
		.load_val (cnt_val),
		.busy     (cnt_busy),
		.done     (cnt_done)
	);

	always @* begin
		nxt_state = state_ff;
		nxt_mode  = mode_ff;
		case (state_ff)
			ST_ACTIVE: begin
				if (sleep_take) begin
					nxt_state = ST_SLEEP;
					nxt_mode  = eff_mode;
				end
			end
			ST_SLEEP: begin
				if (wake_hit) begin
					nxt_state = ST_WAKE;
				end
			end
			ST_WAKE: begin
				if (cnt_done) begin
					nxt_state = ST_ACTIVE;
				end
			end
			default: begin
				nxt_state = ST_ACTIVE;
			end
		endcase
	end

	assign t2_sync_use   = t2_enabled && !t2_async;
	assign disp_sync_use = disp_enabled && !disp_async;
	assign asy_use       = (t2_enabled && t2_async) || (disp_enabled && disp_async);

	// Clock domain and oscillator enables for the next state
	always @* begin
		nxt_cpu  = 1'b1;
		nxt_fls  = 1'b1;
		nxt_io   = 1'b1;
		nxt_cnv  = 1'b1;
		nxt_asy  = 1'b1;
		nxt_sync = 1'b1;
		nxt_mosc = 1'b1;
		nxt_tosc = asy_use;
		if (nxt_state != ST_ACTIVE) begin
			nxt_cpu = 1'b0;
			nxt_fls = 1'b0;
			case (nxt_mode)
				`SLPM_M_IDLE: begin
					nxt_io = 1'b1;
				end
				`SLPM_M_CNR: begin
					nxt_io   = 1'b0;
					nxt_sync = 1'b0;
				end
				`SLPM_M_PSAVE: begin
					nxt_io   = 1'b0;
					nxt_cnv  = 1'b0;
					nxt_asy  = asy_use;
					nxt_sync = t2_sync_use || disp_sync_use;
					nxt_mosc = nxt_sync || debug_enable_fuse;
				end
				`SLPM_M_STBY: begin
					nxt_io   = 1'b0;
					nxt_cnv  = 1'b0;
					nxt_asy  = 1'b0;
					nxt_sync = 1'b0;
					nxt_tosc = 1'b0;
				end
				default: begin
					nxt_io   = 1'b0;
					nxt_cnv  = 1'b0;
					nxt_asy  = 1'b0;
					nxt_sync = 1'b0;
					nxt_tosc = 1'b0;
					nxt_mosc = debug_enable_fuse;
				end
			endcase
			if (nxt_state == ST_WAKE) begin
				nxt_mosc = 1'b1;
			end
		end
		nxt_cmp_off = comparator_disable_bit;
		if ((nxt_state != ST_ACTIVE) && (nxt_mode != `SLPM_M_IDLE)
			&& (nxt_mode != `SLPM_M_CNR) && !comparator_uses_ref) begin
			nxt_cmp_off = 1'b1;
		end
	end

	// Register read mux, sampled in the setup phase
	always @* begin
		rd_mux   = `SLPM_RDATA_RST;
		addr_hit = 1'b1;
		case (widx)
			`SLPM_IDX_SLEEP_CTRL: begin
				rd_mux[3:0] = sctl_ff;
			end
			`SLPM_IDX_PWR_RED: begin
				rd_mux[4:0] = prr_ff;
			end
			`SLPM_IDX_STATUS: begin
				rd_mux[1:0] = state_ff;
				rd_mux[4:2] = mode_ff;
				rd_mux[5]   = ext_ff;
				rd_mux[6]   = cmp_off_ff;
				rd_mux[7]   = cnt_busy;
			end
			default: begin
				addr_hit = 1'b0;
			end
		endcase
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_ff      <= ST_ACTIVE;
			mode_ff       <= `SLPM_M_IDLE;
			sctl_ff       <= `SLPM_SLEEP_CTRL_RST;
			prr_ff        <= `SLPM_PR_RST;
			prdata_ff     <= `SLPM_RDATA_RST;
			resume_ff     <= 1'b0;
			conv_start_ff <= 1'b0;
			cen_d_ff      <= 1'b0;
			ext_ff        <= 1'b0;
			cpu_ff        <= 1'b1;
			fls_ff        <= 1'b1;
			io_ff         <= 1'b1;
			cnv_ff        <= 1'b1;
			asy_ff        <= 1'b1;
			sync_ff       <= 1'b1;
			mosc_ff       <= 1'b1;
			tosc_ff       <= 1'b0;
			cmp_off_ff    <= 1'b0;
			vref_ff       <= 1'b0;
			dib_ff        <= 1'b1;
			pclk_en_ff    <= 5'h1f;
		end else begin
			state_ff  <= nxt_state;
			mode_ff   <= nxt_mode;
			resume_ff <= (state_ff == ST_WAKE) && cnt_done;
			if (apb_wr && (widx == `SLPM_IDX_SLEEP_CTRL)) begin
				sctl_ff <= pwdata[3:0];
			end
			if (apb_wr && (widx == `SLPM_IDX_PWR_RED)) begin
				prr_ff <= pwdata[4:0];
			end
			if (psel && !penable) begin
				prdata_ff <= rd_mux;
			end
			conv_start_ff <= sleep_take && conv_enabled
				&& ((eff_mode == `SLPM_M_IDLE) || (eff_mode == `SLPM_M_CNR));
			cen_d_ff <= conv_enabled;
			// Re-enable sets the flag and wins over a same-cycle start
			if (conv_enabled && !cen_d_ff) begin
				ext_ff <= 1'b1;
			end else if (conv_begin || conv_start_ff) begin
				ext_ff <= 1'b0;
			end
			cpu_ff     <= nxt_cpu;
			fls_ff     <= nxt_fls;
			io_ff      <= nxt_io;
			cnv_ff     <= nxt_cnv;
			asy_ff     <= nxt_asy;
			sync_ff    <= nxt_sync;
			mosc_ff    <= nxt_mosc;
			tosc_ff    <= nxt_tosc;
			cmp_off_ff <= nxt_cmp_off;
			vref_ff    <= brownout_enable || conv_enabled
				|| (comparator_uses_ref && !nxt_cmp_off);
			dib_ff     <= nxt_io || nxt_cnv;
			// Peripheral gating only matters while that peripheral's io or converter clock runs, or for the display its timer 2 domain clock
			pclk_en_ff[`SLPM_PR_CONV]  <= nxt_cnv && !prr_ff[`SLPM_PR_CONV];
			pclk_en_ff[`SLPM_PR_USART] <= nxt_io && !prr_ff[`SLPM_PR_USART];
			pclk_en_ff[`SLPM_PR_SPI]   <= nxt_io && !prr_ff[`SLPM_PR_SPI];
			pclk_en_ff[`SLPM_PR_TIM1]  <= nxt_io && !prr_ff[`SLPM_PR_TIM1];
			pclk_en_ff[`SLPM_PR_DISP]  <= (nxt_io || (nxt_sync && disp_sync_use)
				|| (nxt_asy && disp_enabled && disp_async))
				&& !prr_ff[`SLPM_PR_DISP];
		end
	end

	assign pready   = 1'b1;
	assign pslverr  = psel && penable && !addr_hit;
	assign prdata   = prdata_ff;

	assign core_halt            = (state_ff != ST_ACTIVE);
	assign core_resume          = resume_ff;
	assign core_clock           = cpu_ff;
	assign flash_clock          = fls_ff;
	assign io_clock             = io_ff;
	assign converter_clock      = cnv_ff;
	assign async_clock          = asy_ff;
	assign t2_disp_sync_clk_en  = sync_ff;
	assign main_osc_en          = mosc_ff;
	assign timer_osc_en         = tosc_ff;
	assign periph_clk_en        = pclk_en_ff;
	assign periph_reg_access_en = ~prr_ff;
	assign conv_start           = conv_start_ff;
	assign conv_extended        = ext_ff;
	assign comparator_off       = cmp_off_ff;
	assign vref_en              = vref_ff;
	assign watchdog_run         = watchdog_enable;
	assign brownout_run         = brownout_enable;
	assign dig_input_en         = dib_ff;
	// Wake-detect pin buffers never switch off
	assign wake_input_en        = 1'b1;
endmodule // slpm_ctrl

// ---- verification/slpm_ctrl_assertions.sv ----
// Concurrent checks on the sleep mode controller ports
module slpm_ctrl_chk (
	input wire logic       pclk,
	input wire logic       presetn,
	input wire logic       sleep_instr,
	input wire logic       conv_enabled,
	input wire logic       watchdog_enable,
	input wire logic       comparator_disable_bit,
	input wire logic       core_halt,
	input wire logic       core_resume,
	input wire logic       core_clock,
	input wire logic       flash_clock,
	input wire logic       io_clock,
	input wire logic       converter_clock,
	input wire logic       conv_start,
	input wire logic       comparator_off,
	input wire logic       watchdog_run,
	input wire logic [4:0] periph_clk_en,
	input wire logic [4:0] periph_reg_access_en
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	AST_SLEEP_ON_INSTR: assert property ($rose(core_halt) |-> $past(sleep_instr))
		else $error("halt without sleep instruction");
	AST_HALT_HOLDS: assert property ($rose(core_halt) |-> core_halt[*5])
		else $error("halt shorter than wake delay");
	AST_RESUME_ONCE: assert property (core_resume |-> !core_halt && $past(core_halt) ##1 !core_resume)
		else $error("resume pulse wrong");
	AST_CPU_STOPPED: assert property (core_halt |-> !core_clock && !flash_clock)
		else $error("core or flash clock running in sleep");
	AST_CONV_AUTO: assert property ($rose(core_halt) && converter_clock && conv_enabled |-> conv_start)
		else $error("no conversion on sleep entry");
	AST_DEEP_IO_OFF: assert property (core_halt && !converter_clock |-> !io_clock)
		else $error("io clock running in deep sleep");
	AST_PRR_STOPS: assert property ($fell(periph_reg_access_en[2]) |=> !periph_clk_en[2])
		else $error("peripheral clock not stopped");
	AST_WDOG_RUNS: assert property (watchdog_run == watchdog_enable)
		else $error("watchdog run differs from enable");
	AST_CMP_OFF: assert property (comparator_disable_bit |=> comparator_off)
		else $error("comparator not off");
endmodule // slpm_ctrl_chk

bind slpm_ctrl slpm_ctrl_chk slpm_ctrl_chk_inst (
	.pclk, .presetn, .sleep_instr, .conv_enabled, .watchdog_enable, .comparator_disable_bit,
	.core_halt, .core_resume, .core_clock, .flash_clock, .io_clock, .converter_clock,
	.conv_start, .comparator_off, .watchdog_run, .periph_clk_en, .periph_reg_access_en
);

// ---- verification/slpm_core_mdl.sv ----
// Core and wake-source model driving the sleep controller
module slpm_core_mdl (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        core_halt,
	input  wire logic        sleep_req,
	input  wire logic [10:0] wake_req,
	output wire logic        sleep_instr,
	output wire logic [10:0] wake_src
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [10:0] held;
	// A halted core executes nothing
	assign sleep_instr = sleep_req & ~core_halt;
	// Raised requests stay up until the core runs again
	always @(posedge pclk or negedge presetn) begin
		if (!presetn)
			held <= '0;
		else if (!core_halt)
			held <= '0;
		else
			held <= held | wake_req;
	end
	assign wake_src = wake_req | held;
endmodule // slpm_core_mdl

// ---- verification/slpm_ctrl_tb_top.sv ----
// Self-checking bench for the sleep mode controller
module slpm_ctrl_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	localparam [11:0] A_CTL = 12'h0cc;
	localparam [11:0] A_PRR = 12'h0d0;
	logic        pclk, presetn, psel, penable, pwrite, sleep_req, slv;
	logic        dbg, bo, wd, gie, t2ie, conv_en, conv_beg, cmp_dis;
	logic [3:0]  css;
	logic [5:0]  cfg;
	logic [10:0] wake_req;
	logic [11:0] paddr;
	logic [31:0] pwdata, rd;
	wire         pready, pslverr, sleep_instr, core_halt, core_resume, core_clock;
	wire         flash_clock, io_clock, converter_clock, main_osc_en, conv_start;
	wire         conv_extended, comparator_off, vref_en, dig_input_en;
	wire         async_clock, t2_disp_sync_clk_en, timer_osc_en;
	wire [4:0]   periph_clk_en, periph_reg_access_en, lvl;
	wire [10:0]  wake_src;
	wire [31:0]  prdata;
	integer      n_errors = 0;
	integer      n_compared = 0;
	integer      n;
	assign lvl = {io_clock, converter_clock, main_osc_en, dig_input_en, comparator_off};

	slpm_core_mdl slpm_core_mdl_inst (
		.pclk(pclk), .presetn(presetn), .core_halt(core_halt), .sleep_req(sleep_req),
		.wake_req(wake_req), .sleep_instr(sleep_instr), .wake_src(wake_src)
	);
	slpm_ctrl #(.WAKE_XTAL_CYC(16'h0008), .WAKE_RC_CYC(16'h0004)) slpm_ctrl_inst (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .sleep_instr(sleep_instr), .clock_source_select(css),
		.debug_enable_fuse(dbg), .brownout_enable(bo), .watchdog_enable(wd),
		.global_irq_en(gie), .t2_ovf_irq_en(t2ie), .t2_cmp_irq_en(cfg[0]),
		.t2_enabled(cfg[1]), .t2_async(cfg[2]), .disp_enabled(cfg[3]), .disp_async(cfg[4]),
		.conv_enabled(conv_en), .conv_begin(conv_beg), .comparator_disable_bit(cmp_dis),
		.comparator_uses_ref(cfg[5]), .reset_wake(wake_src[7]),
		.external_irq_zero(wake_src[2]), .ext_irq_edge(wake_src[9]),
		.pin_change(wake_src[0]), .serial_start(wake_src[3]), .conv_done_irq(wake_src[4]),
		.display_irq(wake_src[5]), .timer2_ovf(wake_src[6]), .timer2_cmp(wake_src[8]),
		.nvm_ready_irq(wake_src[10]), .other_io_irq(wake_src[1]), .core_halt(core_halt),
		.core_resume(core_resume), .core_clock(core_clock), .flash_clock(flash_clock),
		.io_clock(io_clock), .converter_clock(converter_clock),
		.async_clock(async_clock), .t2_disp_sync_clk_en(t2_disp_sync_clk_en),
		.main_osc_en(main_osc_en), .timer_osc_en(timer_osc_en),
		.periph_clk_en(periph_clk_en), .periph_reg_access_en(periph_reg_access_en),
		.conv_start(conv_start), .conv_extended(conv_extended),
		.comparator_off(comparator_off), .vref_en(vref_en), .watchdog_run(),
		.brownout_run(), .dig_input_en(dig_input_en), .wake_input_en()
	);

	task automatic print_verdict;
		$display("compared %0d mismatches %0d", n_compared, n_errors);
		if (n_errors == 0 && n_compared > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		n_compared++;
		if (got !== exp) begin
			n_errors++;
			$display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask

	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		integer k;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		k = 0;
		do begin
			@(posedge pclk);
			k++;
		end while (pready !== 1'b1 && k < 20);
		if (k >= 20) begin
			n_errors++;
			print_verdict();
		end
		rd = prdata;
		slv = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic enter(input logic [3:0] ctl, input logic [4:0] lv, input logic [4:0] pce);
		apb(1'b1, A_CTL, {28'h000_0000, ctl});
		@(posedge pclk);
		sleep_req <= 1'b1;
		@(posedge pclk);
		sleep_req <= 1'b0;
		repeat (3) @(posedge pclk);
		#1;
		chk(core_halt, ctl[0], "halt");
		chk(lvl, lv, "domains");
		chk(periph_clk_en, pce, "periph clocks");
		chk(core_clock | flash_clock, !ctl[0], "core clocks");
		@(posedge pclk);
	endtask

	task automatic wake(input logic [10:0] wk, input integer exp_n);
		wake_req <= wk;
		n = 0;
		do begin
			@(posedge pclk);
			#1;
			n++;
		end while (core_resume !== 1'b1 && n < 40);
		if (exp_n == 40) begin
			chk(core_halt, 1'b1, "still asleep");
		end else if (n >= 40) begin
			n_errors++;
			print_verdict();
		end
		chk(n, exp_n, "wake cycles");
		@(posedge pclk);
		wake_req <= '0;
	endtask

	initial begin
		pclk = 1'b0;
		forever #2 pclk = ~pclk;
	end

	initial begin
		{presetn, psel, penable, pwrite, sleep_req, dbg, bo, gie, t2ie} = '0;
		{conv_en, conv_beg, cmp_dis, cfg, wake_req, paddr, pwdata} = '0;
		wd = 1'b1;
		css = 4'h8;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		conv_en <= 1'b1;
		apb(1'b0, A_CTL, 32'h0000_0000);
		chk(rd, 32'h0000_0000, "control reset");
		enter(4'b0100, 5'b11110, 5'h1f);
		apb(1'b0, 12'h0e0, 32'h0000_0000);
		chk(slv, 1'b1, "unmapped");
		$display("test access done");
		apb(1'b1, A_PRR, 32'h0000_0004);
		apb(1'b0, A_PRR, 32'h0000_0000);
		chk(rd, 32'h0000_0004, "prr readback");
		chk(periph_reg_access_en, 5'h1b, "access");
		chk(conv_extended, 1'b1, "extended");
		enter(4'b0001, 5'b11110, 5'h1b);
		wake(11'h002, 6);
		apb(1'b1, A_PRR, 32'h0000_0000);
		repeat (2) @(posedge pclk);
		#1;
		chk(periph_clk_en, 5'h1f, "restart");
		$display("test peripheral stop done");
		enter(4'b0011, 5'b01110, 5'h01);
		wake(11'h002, 40);
		wake(11'h010, 6);
		enter(4'b0101, 5'b00001, 5'h00);
		wake(11'h200, 40);
		wake(11'h004, 14);
		cfg <= 6'h06;
		enter(4'b0111, 5'b00001, 5'h00);
		chk({async_clock, t2_disp_sync_clk_en, timer_osc_en}, 3'b101, "timer domain");
		wake(11'h040, 40);
		gie <= 1'b1;
		t2ie <= 1'b1;
		wake(11'h040, 14);
		enter(4'b1101, 5'b00101, 5'h00);
		wake(11'h008, 8);
		dbg <= 1'b1;
		enter(4'b0101, 5'b00101, 5'h00);
		chk({async_clock, t2_disp_sync_clk_en, timer_osc_en}, 3'b000, "deep domains");
		wake(11'h080, 14);
		dbg <= 1'b0;
		css <= 4'h0;
		enter(4'b0101, 5'b00001, 5'h00);
		wake(11'h001, 10);
		enter(4'b1101, 5'b11110, 5'h1f);
		wake(11'h001, 6);
		enter(4'b1001, 5'b11110, 5'h1f);
		wake(11'h400, 6);
		$display("test sleep modes done");
		cmp_dis <= 1'b1;
		conv_en <= 1'b0;
		wd <= 1'b0;
		repeat (3) @(posedge pclk);
		#1;
		chk(comparator_off, 1'b1, "comparator");
		chk(vref_en, 1'b0, "reference unused");
		@(posedge pclk);
		bo <= 1'b1;
		repeat (3) @(posedge pclk);
		#1;
		chk(vref_en, 1'b1, "reference for detector");
		$display("test analog done");
		print_verdict();
	end
endmodule // slpm_ctrl_tb_top
